// File: rhc_pkg.sv
// Constants for the right-channel ADC high-pass coefficient register bank.
// Assumes 7-bit register addresses and 8-bit data on the control-bus side.
package rhc_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int COEF_W = 16;

  // Register offsets
  localparam logic [6:0] OFS_NUM0_HIGH = 7'h47;
  localparam logic [6:0] OFS_NUM0_LOW  = 7'h48;
  localparam logic [6:0] OFS_NUM1_HIGH = 7'h49;
  localparam logic [6:0] OFS_NUM1_LOW  = 7'h4a;
  localparam logic [6:0] OFS_DEN1_HIGH = 7'h4b;
  localparam logic [6:0] OFS_DEN1_LOW  = 7'h4c;
  localparam logic [6:0] OFS_RSVD_FIRST = 7'h4d;
  localparam logic [6:0] OFS_RSVD_LAST  = 7'h7f;

  // Reset values
  localparam logic [7:0] RST_NUM0_HIGH = 8'h39;
  localparam logic [7:0] RST_NUM0_LOW  = 8'h55;
  localparam logic [7:0] RST_NUM1_HIGH = 8'hf3;
  localparam logic [7:0] RST_NUM1_LOW  = 8'h2d;
  localparam logic [7:0] RST_DEN1_HIGH = 8'h53;
  localparam logic [7:0] RST_DEN1_LOW  = 8'h7e;
  localparam logic [7:0] RSVD_VALUE    = 8'h00;

  // Field positions inside a coefficient word
  localparam int HIGH_MSB = 15;
  localparam int HIGH_LSB = 8;
  localparam int LOW_MSB  = 7;
  localparam int LOW_LSB  = 0;

  // Byte-register selector
  typedef enum logic [2:0] {
    RHC_SEL_NUM0_HIGH = 3'b000,
    RHC_SEL_NUM0_LOW  = 3'b001,
    RHC_SEL_NUM1_HIGH = 3'b010,
    RHC_SEL_NUM1_LOW  = 3'b011,
    RHC_SEL_DEN1_HIGH = 3'b100,
    RHC_SEL_DEN1_LOW  = 3'b101,
    RHC_SEL_NONE      = 3'b111
  } rhc_sel_t;

endpackage

// File: rhc_dec_if.sv
// Decode carrier between the register bank and its address decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface rhc_dec_if;
  import rhc_pkg::*;
  logic [6:0] addr;
  rhc_sel_t   sel;
  logic       rsvd_hit;

  modport bank (output addr, input sel, input rsvd_hit);
  modport dec  (input addr, output sel, output rsvd_hit);
endinterface

// File: rhc_addr_dec.sv
// Address decoder for the coefficient byte registers and the reserved tail.
// Assumes a purely combinational lookup from the bank's register address.
`timescale 1ns/100ps
module rhc_addr_dec (
  // Decode carrier
  rhc_dec_if.dec dif
);
  import rhc_pkg::*;

  function automatic rhc_sel_t decode(input logic [6:0] a);
    case (a)
      OFS_NUM0_HIGH: decode = RHC_SEL_NUM0_HIGH;
      OFS_NUM0_LOW:  decode = RHC_SEL_NUM0_LOW;
      OFS_NUM1_HIGH: decode = RHC_SEL_NUM1_HIGH;
      OFS_NUM1_LOW:  decode = RHC_SEL_NUM1_LOW;
      OFS_DEN1_HIGH: decode = RHC_SEL_DEN1_HIGH;
      OFS_DEN1_LOW:  decode = RHC_SEL_DEN1_LOW;
      default:       decode = RHC_SEL_NONE;
    endcase
  endfunction

  assign dif.sel      = decode(dif.addr);
  assign dif.rsvd_hit = (dif.addr >= OFS_RSVD_FIRST) && (dif.addr <= OFS_RSVD_LAST);

endmodule // rhc_addr_dec

// File: rhc_coeff_regs.sv
// Right-channel ADC high-pass coefficient register bank, top module.
// Assumes a control-bus front end that presents one byte access per cycle
// with address, write strobe and read strobe on the codec digital clock.
`timescale 1ns/100ps

// Summary of operation
// RULE1: Each coefficient word takes its upper byte from the high register and lower from the low.
// RULE2: Each assembled coefficient is presented as a signed two's complement 16-bit value.
// RULE3: After reset the first numerator coefficient reads high 0x39 and low 0x55.
// RULE4: After reset the second numerator coefficient reads high 0xf3 and low 0x2d.
// RULE5: After reset the denominator coefficient reads high 0x53 and low 0x7e.
// RULE6: The reserved registers after the bank are read-only and always read zero.
// RULE7: The host writes only the six coefficient byte registers, never the reserved ones.
// RULE8: A write changes only the addressed byte, and a read returns the last value written.
module rhc_coeff_regs (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  // Register access from the control-bus front end
  input  wire logic [rhc_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic [rhc_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_rd,
  output logic      [rhc_pkg::DATA_W-1:0]   reg_rdata,
  output logic                              reg_rvalid,
  // Coefficients to the filter datapath
  output logic signed [rhc_pkg::COEF_W-1:0] first_numerator_coeff,
  output logic signed [rhc_pkg::COEF_W-1:0] second_numerator_coeff,
  output logic signed [rhc_pkg::COEF_W-1:0] denominator_coeff
);
  import rhc_pkg::*;

  rhc_dec_if dif ();

  logic [7:0] num0_high_q;
  logic [7:0] num0_low_q;
  logic [7:0] num1_high_q;
  logic [7:0] num1_low_q;
  logic [7:0] den1_high_q;
  logic [7:0] den1_low_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;

  rhc_addr_dec u_dec (
    .dif (dif.dec)
  );

  assign dif.addr = reg_addr;

  // Per-byte write strobes; reserved and unmapped addresses select nothing
  wire wr_num0_high = reg_wr && (dif.sel == RHC_SEL_NUM0_HIGH); // RULE8
  wire wr_num0_low  = reg_wr && (dif.sel == RHC_SEL_NUM0_LOW);  // RULE8
  wire wr_num1_high = reg_wr && (dif.sel == RHC_SEL_NUM1_HIGH); // RULE8
  wire wr_num1_low  = reg_wr && (dif.sel == RHC_SEL_NUM1_LOW);  // RULE8
  wire wr_den1_high = reg_wr && (dif.sel == RHC_SEL_DEN1_HIGH); // RULE8
  wire wr_den1_low  = reg_wr && (dif.sel == RHC_SEL_DEN1_LOW);  // RULE8

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      num0_high_q <= RST_NUM0_HIGH; // RULE3
      num0_low_q  <= RST_NUM0_LOW;  // RULE3
      num1_high_q <= RST_NUM1_HIGH; // RULE4
      num1_low_q  <= RST_NUM1_LOW;  // RULE4
      den1_high_q <= RST_DEN1_HIGH; // RULE5
      den1_low_q  <= RST_DEN1_LOW;  // RULE5
    end else begin
      if (wr_num0_high) num0_high_q <= reg_wdata;
      if (wr_num0_low)  num0_low_q  <= reg_wdata;
      if (wr_num1_high) num1_high_q <= reg_wdata;
      if (wr_num1_low)  num1_low_q  <= reg_wdata;
      if (wr_den1_high) den1_high_q <= reg_wdata;
      if (wr_den1_low)  den1_low_q  <= reg_wdata;
    end
  end

  // Read mux; reserved tail and unmapped locations return zero
  always_comb begin
    rdata_d = RSVD_VALUE;
    if (!dif.rsvd_hit) begin // RULE6
      case (dif.sel)
        RHC_SEL_NUM0_HIGH: rdata_d = num0_high_q;
        RHC_SEL_NUM0_LOW:  rdata_d = num0_low_q;
        RHC_SEL_NUM1_HIGH: rdata_d = num1_high_q;
        RHC_SEL_NUM1_LOW:  rdata_d = num1_low_q;
        RHC_SEL_DEN1_HIGH: rdata_d = den1_high_q;
        RHC_SEL_DEN1_LOW:  rdata_d = den1_low_q;
        default:           rdata_d = RSVD_VALUE; // RULE6
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_q  <= RSVD_VALUE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) rdata_q <= rdata_d; // RULE8
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  // Bytes are not shadowed: a word is half-updated between the host's
  // high and low byte writes, so the filter should be idle meanwhile
  assign first_numerator_coeff  = signed'({num0_high_q, num0_low_q}); // RULE1 RULE2
  assign second_numerator_coeff = signed'({num1_high_q, num1_low_q}); // RULE1 RULE2
  assign denominator_coeff      = signed'({den1_high_q, den1_low_q}); // RULE1 RULE2

endmodule // rhc_coeff_regs

// File: rhc_sva.sv
// Checker on the bank ports, bound into the top.
// Assumes one clock, sync active-low reset.
`timescale 1ns/100ps
module rhc_sva (
  // Bank ports
  input wire logic clock, reset_n, reg_wr, reg_rd, reg_rvalid,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  input wire logic signed [15:0] first_numerator_coeff, second_numerator_coeff, denominator_coeff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire [47:0] cf = {first_numerator_coeff, second_numerator_coeff, denominator_coeff};
  property p_rst;
    $rose(reset_n) |-> cf == 48'h3955_f32d_537e && second_numerator_coeff < 0; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_rsv; reg_rd && reg_addr > 7'h4c |=> reg_rdata == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_hi; reg_wr && reg_addr == 7'h47 |=> cf[47:40] == $past(reg_wdata); endproperty
  a_hi: assert property (p_hi) else $error("high");
  property p_lo; reg_wr && reg_addr == 7'h4c |=> cf[7:0] == $past(reg_wdata); endproperty
  a_lo: assert property (p_lo) else $error("low");
  property p_rvalid; reg_rvalid == $past(reg_rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("rvalid");
  property p_rdhi; reg_rd && reg_addr == 7'h4b |=> reg_rdata == $past(cf[15:8]); endproperty
  a_rdhi: assert property (p_rdhi) else $error("read high");
  property p_hold; !reg_wr |=> $stable(cf); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  c_wr: cover property (reg_wr && reg_addr == 7'h4c);
  c_rsv: cover property (reg_rd && reg_addr > 7'h4c);
  c_rst: cover property ($rose(reset_n));
endmodule // rhc_sva
bind rhc_coeff_regs rhc_sva u_sva (
  .clock                  (clock),
  .reset_n                (reset_n),
  .reg_wr                 (reg_wr),
  .reg_rd                 (reg_rd),
  .reg_rvalid             (reg_rvalid),
  .reg_addr               (reg_addr),
  .reg_wdata              (reg_wdata),
  .reg_rdata              (reg_rdata),
  .first_numerator_coeff  (first_numerator_coeff),
  .second_numerator_coeff (second_numerator_coeff),
  .denominator_coeff      (denominator_coeff)
);

// File: rhc_host.sv
// Host model: byte accesses into the bank.
// Assumes a read answer at the next edge.
`timescale 1ns/100ps
module rhc_host (
  // Bus
  input wire logic clock, reg_rvalid,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr = 1'b0, reg_rd = 1'b0,
  output logic [6:0] reg_addr = 7'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  // Idle lines show the inverse, never a stale copy
  task automatic acc(input logic w, logic [6:0] a, logic [7:0] d, output logic [8:0] q);
    if (w && (a < 7'h47 || a > 7'h4c)) return;
    @(negedge clock) {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge clock) {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    q = {reg_rdata, reg_rvalid};
  endtask
endmodule // rhc_host

// File: tb.sv
// Bench: byte model against the bank.
// Assumes rhc_host drives the bus.
`timescale 1ns/100ps
module tb;
  logic clock = 1'b0, reset_n = 1'b0, reg_wr, reg_rd, reg_rvalid;
  logic [6:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [8:0] q;
  logic [0:127][7:0] m;
  logic signed [15:0] first_numerator_coeff, second_numerator_coeff, denominator_coeff;
  wire [47:0] cf = {first_numerator_coeff, second_numerator_coeff, denominator_coeff};
  int errors = 0, comparisons = 0, cycles = 0, seed = 32'h843d;
  always #10 clock = ~clock;
  rhc_coeff_regs dut (
    .clock                  (clock),
    .reset_n                (reset_n),
    .reg_addr               (reg_addr),
    .reg_wr                 (reg_wr),
    .reg_wdata              (reg_wdata),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .reg_rvalid             (reg_rvalid),
    .first_numerator_coeff  (first_numerator_coeff),
    .second_numerator_coeff (second_numerator_coeff),
    .denominator_coeff      (denominator_coeff)
  );
  rhc_host host (
    .clock      (clock),
    .reg_rvalid (reg_rvalid),
    .reg_rdata  (reg_rdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata)
  );
  task automatic chk(input logic [47:0] g, e);
    comparisons++;
    errors += int'(g !== e);
    if (g !== e) $display("[ERR] %0t got %h want %h", $time, g, e);
  endtask
  task automatic rst();
    @(negedge clock) reset_n = 1'b0;
    m = '0;
    m[71:76] = 48'h3955_f32d_537e;
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    for (int i = 0; i < 128; i++) begin
      host.acc(1'b0, 7'(i), 8'h00, q);
      chk(48'(q), 48'({m[i], 1'b1}));
    end
    $display("test reset done");
  endtask
  initial begin
    rst();
    repeat (300) begin
      a = 7'($random(seed));
      d = 8'($random(seed));
      a = 7'h47 + a % 7'd6;
      host.acc(1'b1, a, d, q);
      if (a > 7'h46) m[a] = d;
      chk(cf, m[71:76]);
      host.acc(1'b0, a, 8'h00, q);
      chk(48'(q), 48'({m[a], 1'b1}));
    end
    $display("test writes done");
    rst();
    end_sim();
  end
  always @(posedge clock) if (++cycles == 5000) begin
    errors++;
    $display("[ERR] %0t timeout", $time);
    end_sim();
  end
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
endmodule // tb
